// [src/adc_compute_cfg.svh]
// Register offsets, field positions, reset values for converter post-processing.
// Assumes a 32-bit AXI4-Lite register bus with a 12-bit byte address.
// Overview of operation
// - At conversion start, copy filter value or last result into previous store by select bit.
// - Filter mode uses shift field as time constant two to that power, unity gain.
// - Accumulate, average and burst modes right-shift the running sum by shift field.
// - Basic mode ignores the shift field entirely; accumulate honours it.
// - Writing one to clear command clears running sum, wrapped flag and tally.
// - Clear command reads zero when idle or once clearing has finished.
// - Mode field: 100 filter, 011 burst, 010 average, 001 accumulate, 101-111 reserved.
// - Control register: select bit 7, shift 6:4, clear 3, mode 2:0, reset zero.
// - Clear command drops by itself only after the clearing has actually completed.
`ifndef ADC_COMPUTE_CFG_SVH
`define ADC_COMPUTE_CFG_SVH
`define ADC_CTRL_IDX 10'h113
`define ADC_CTRL_ADDR {`ADC_CTRL_IDX, 2'b00}
`define ADC_SUM_ADDR 12'h450
`define ADC_FILT_ADDR 12'h454
`define ADC_PREV_ADDR 12'h458
`define ADC_STAT_ADDR 12'h45c
`define ADC_RPT_ADDR 12'h460
`define ADC_CTRL_RST 8'h00
`define ADC_RPT_RST 8'h00
`define PSEL_BIT 7
`define SHIFT_MSB 6
`define SHIFT_LSB 4
`define CLR_BIT 3
`define MODE_MSB 2
`define MODE_LSB 0
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

// [src/adc_compute_pkg.sv]
// Types shared by the converter post-processing control and its datapath.
// Assumes the constants header is included alongside.
package adc_compute_pkg;
  // Computation mode encodings
  typedef enum logic [2:0] {
    MODE_BASIC = 3'h0,
    MODE_ACCUM = 3'h1,
    MODE_AVG = 3'h2,
    MODE_BURST = 3'h3,
    MODE_LPF = 3'h4
  } compute_mode_select_t;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic prior_source_select;
    logic [2:0] result_shift_amount;
    logic sum_clear_command;
    logic [2:0] compute_mode_select;
  } ctrl_fields_t;

  // Conversion events from the converter, same clock
  typedef struct packed {
    logic start;
    logic done;
    logic [11:0] value;
  } conv_in_t;

  // Clear sequencer, one-hot
  typedef enum logic [1:0] {
    CLR_IDLE = 2'h1,
    CLR_BUSY = 2'h2
  } clr_state_t;
endpackage : adc_compute_pkg

// [src/adc_accum_core.sv]
// Accumulator, averager and filter datapath with self-timed clear sequence.
// Assumes conversion events on the same clock; one done per cycle at most.
`timescale 1ns/1ps
`include "adc_compute_cfg.svh"
module adc_accum_core #(
  parameter int SUM_W = 18
) (
  input wire logic ref_clk_i, // System clock
  input wire logic arst_n_i, // Async reset, active low
  input wire adc_compute_pkg::ctrl_fields_t cfg_i, // Control fields
  input wire logic [7:0] repeat_target_i, // Samples per average
  input wire adc_compute_pkg::conv_in_t conv_i, // Conversion events
  input wire logic clear_req_i, // Clear request pulse
  output logic clear_done_o, // Clearing completes this cycle
  output logic [SUM_W-1:0] running_sum_o, // Running sum
  output logic sum_wrapped_flag_o, // Sum overflowed
  output logic [7:0] sample_tally_o, // Samples taken
  output logic [SUM_W-1:0] filtered_value_o, // Computed output
  output logic [11:0] prev_value_o, // Previous-value store
  output logic result_valid_o // New output pulse
);
  import adc_compute_pkg::*;

  logic [SUM_W-1:0] sum_ff, nxt_sum, filt_ff, nxt_filt;
  logic wrap_ff, nxt_wrap, out_now;
  logic [7:0] tally_ff, nxt_tally;
  logic [11:0] last_res_ff, prev_ff;
  logic valid_ff;
  logic [SUM_W:0] sum_ext;
  clr_state_t clr_state_ff;
  compute_mode_select_t mode;

  assign mode = compute_mode_select_t'(cfg_i.compute_mode_select);
  assign sum_ext = {1'b0, sum_ff} + {{(SUM_W-11){1'b0}}, conv_i.value};

  // Next datapath values for one finished conversion
  always_comb begin
    nxt_sum = sum_ff;
    nxt_wrap = wrap_ff;
    nxt_tally = tally_ff;
    nxt_filt = filt_ff;
    out_now = 1'b0;
    unique case (mode)
      MODE_BASIC: begin
        nxt_filt = {{(SUM_W-12){1'b0}}, conv_i.value};
        out_now = 1'b1;
      end
      MODE_ACCUM: begin
        nxt_sum = sum_ext[SUM_W-1:0];
        nxt_wrap = wrap_ff | sum_ext[SUM_W];
        nxt_tally = tally_ff + 8'h01;
        nxt_filt = nxt_sum >> cfg_i.result_shift_amount;
        out_now = 1'b1;
      end
      MODE_AVG, MODE_BURST: begin
        nxt_sum = sum_ext[SUM_W-1:0];
        nxt_wrap = wrap_ff | sum_ext[SUM_W];
        nxt_tally = tally_ff + 8'h01;
        // Average completes at the repeat target; tally 0 target means 1
        if (nxt_tally >= repeat_target_i) begin
          nxt_filt = nxt_sum >> cfg_i.result_shift_amount;
          out_now = 1'b1;
          nxt_sum = '0;
          nxt_tally = 8'h00;
        end
      end
      MODE_LPF: begin
        // Sum holds output times 2^shift, so the gain stays unity
        nxt_sum = sum_ff - (sum_ff >> cfg_i.result_shift_amount)
                  + {{(SUM_W-12){1'b0}}, conv_i.value};
        nxt_filt = nxt_sum >> cfg_i.result_shift_amount;
        out_now = 1'b1;
      end
      default: begin
        out_now = 1'b0; // Reserved modes do nothing
      end
    endcase
  end

  // Clear sequencer: request, then one busy cycle of clearing
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clr_state_ff <= CLR_IDLE;
    end else begin
      unique case (clr_state_ff)
        CLR_IDLE: if (clear_req_i) clr_state_ff <= CLR_BUSY;
        CLR_BUSY: clr_state_ff <= CLR_IDLE;
        default: clr_state_ff <= CLR_IDLE;
      endcase
    end
  end
  assign clear_done_o = (clr_state_ff == CLR_BUSY);

  // Accumulation state; clearing beats a conversion
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sum_ff <= '0;
      wrap_ff <= 1'b0;
      tally_ff <= 8'h00;
    end else if (clr_state_ff == CLR_BUSY) begin
      sum_ff <= '0;
      wrap_ff <= 1'b0;
      tally_ff <= 8'h00;
    end else if (conv_i.done) begin
      sum_ff <= nxt_sum;
      wrap_ff <= nxt_wrap;
      tally_ff <= nxt_tally;
    end
  end

  // Output value and valid pulse
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      filt_ff <= '0;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= conv_i.done & out_now & (clr_state_ff != CLR_BUSY);
      if (conv_i.done && out_now && clr_state_ff != CLR_BUSY) filt_ff <= nxt_filt;
    end
  end

  // Last result and previous-value store
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_res_ff <= 12'h000;
      prev_ff <= 12'h000;
    end else begin
      if (conv_i.done) last_res_ff <= conv_i.value;
      if (conv_i.start) begin
        prev_ff <= cfg_i.prior_source_select ? filt_ff[11:0] : last_res_ff;
      end
    end
  end

  assign running_sum_o = sum_ff;
  assign sum_wrapped_flag_o = wrap_ff;
  assign sample_tally_o = tally_ff;
  assign filtered_value_o = filt_ff;
  assign prev_value_o = prev_ff;
  assign result_valid_o = valid_ff;

  a_prev_source: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    conv_i.start |=> prev_ff == ($past(cfg_i.prior_source_select) ? $past(filt_ff[11:0])
                                 : $past(last_res_ff)))
    else $error("previous store took wrong source");
  a_basic_plain: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (conv_i.done && mode == MODE_BASIC && clr_state_ff == CLR_IDLE)
    |=> valid_ff && filt_ff == {{(SUM_W-12){1'b0}}, $past(conv_i.value)})
    else $error("basic mode output not the plain result");
  a_clear_effect: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    clear_req_i && clr_state_ff == CLR_IDLE |=> ##1 sum_ff == '0 && !wrap_ff && tally_ff == 8'h00)
    else $error("clear left accumulator state");
  a_accum_shift: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (conv_i.done && mode == MODE_ACCUM && clr_state_ff == CLR_IDLE)
    |=> filt_ff == (sum_ff >> $past(cfg_i.result_shift_amount)))
    else $error("accumulate output not shifted sum");
endmodule : adc_accum_core

// [src/adc_compute_ctrl.sv]
// Converter post-processing control: AXI4-Lite register slave plus datapath.
// Assumes conversion events come from logic on the same system clock.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "adc_compute_cfg.svh"
module adc_compute_ctrl #(
  parameter int ADDR_W = 12,
  parameter int SUM_W = 18
) (
  input wire logic ref_clk_i, // System clock, 25 MHz
  input wire logic arst_n_i, // Async reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire adc_compute_pkg::conv_in_t conv_i, // Start, done and result
  output logic [SUM_W-1:0] filtered_value_o, // Computed output
  output logic result_valid_o, // New output pulse
  output logic [11:0] prev_value_o // Previous-value store
);
  import adc_compute_pkg::*;

  ctrl_fields_t ctrl_ff;
  logic [7:0] rpt_ff;
  logic aw_full_ff, w_full_ff, bvalid_ff, rvalid_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff, nxt_rdata;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff, nxt_rresp;
  logic do_write, wr_ctrl, wr_rpt, wr_hit, rd_take, rd_hit;
  logic clear_req, clear_done;
  logic [SUM_W-1:0] running_sum;
  logic sum_wrapped_flag;
  logic [7:0] sample_tally;

  // Handshake readies; one write and one read in flight
  assign s_axi_awready = !aw_full_ff && !bvalid_ff;
  assign s_axi_wready = !w_full_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Write decode once both address and data are held
  assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;
  assign wr_ctrl = do_write && awaddr_ff == ADDR_W'(`ADC_CTRL_ADDR) && wstrb_ff[0];
  assign wr_rpt = do_write && awaddr_ff == ADDR_W'(`ADC_RPT_ADDR) && wstrb_ff[0];
  assign wr_hit = awaddr_ff == ADDR_W'(`ADC_CTRL_ADDR) || awaddr_ff == ADDR_W'(`ADC_RPT_ADDR)
                  || awaddr_ff == ADDR_W'(`ADC_SUM_ADDR) || awaddr_ff == ADDR_W'(`ADC_FILT_ADDR)
                  || awaddr_ff == ADDR_W'(`ADC_PREV_ADDR) || awaddr_ff == ADDR_W'(`ADC_STAT_ADDR);
  assign clear_req = wr_ctrl && wdata_ff[`CLR_BIT];

  // Write channel capture and response
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bresp_ff <= `AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Control register; a fresh clear write beats the completion drop
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_ff <= ctrl_fields_t'(`ADC_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_ff <= ctrl_fields_t'(wdata_ff[7:0]);
    end else if (clear_done) begin
      ctrl_ff.sum_clear_command <= 1'b0;
    end
  end

  // Repeat target register
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rpt_ff <= `ADC_RPT_RST;
    end else if (wr_rpt) begin
      rpt_ff <= wdata_ff[7:0];
    end
  end

  // Read mux; unmapped addresses answer zero with an error
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = `AXI_OKAY;
    rd_hit = 1'b1;
    if (s_axi_araddr == ADDR_W'(`ADC_CTRL_ADDR)) begin
      nxt_rdata[7:0] = ctrl_ff;
    end else if (s_axi_araddr == ADDR_W'(`ADC_RPT_ADDR)) begin
      nxt_rdata[7:0] = rpt_ff;
    end else if (s_axi_araddr == ADDR_W'(`ADC_SUM_ADDR)) begin
      nxt_rdata[SUM_W-1:0] = running_sum;
    end else if (s_axi_araddr == ADDR_W'(`ADC_FILT_ADDR)) begin
      nxt_rdata[SUM_W-1:0] = filtered_value_o;
    end else if (s_axi_araddr == ADDR_W'(`ADC_PREV_ADDR)) begin
      nxt_rdata[11:0] = prev_value_o;
    end else if (s_axi_araddr == ADDR_W'(`ADC_STAT_ADDR)) begin
      nxt_rdata[8:0] = {sum_wrapped_flag, sample_tally};
    end else begin
      rd_hit = 1'b0;
      nxt_rresp = `AXI_SLVERR;
    end
  end
  assign rd_take = s_axi_arvalid && s_axi_arready;

  // Read channel
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `AXI_OKAY;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Datapath
  adc_accum_core #(
    .SUM_W(SUM_W)
  ) u_core (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .cfg_i(ctrl_ff),
    .repeat_target_i(rpt_ff),
    .conv_i(conv_i),
    .clear_req_i(clear_req),
    .clear_done_o(clear_done),
    .running_sum_o(running_sum),
    .sum_wrapped_flag_o(sum_wrapped_flag),
    .sample_tally_o(sample_tally),
    .filtered_value_o(filtered_value_o),
    .prev_value_o(prev_value_o),
    .result_valid_o(result_valid_o)
  );

  a_ctrl_write: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    wr_ctrl |=> ctrl_ff[7:4] == $past(wdata_ff[7:4]) && ctrl_ff[2:0] == $past(wdata_ff[2:0]))
    else $error("control register write lost");
  a_mode_field: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    wr_ctrl |=> u_core.mode == compute_mode_select_t'($past(wdata_ff[2:0])))
    else $error("mode field not steering datapath");
  a_clear_holds: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    clear_req |=> ctrl_ff.sum_clear_command ##1 !ctrl_ff.sum_clear_command || wr_ctrl)
    else $error("clear command not held until done");
  a_clear_reads: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    clear_done && !wr_ctrl |=> !ctrl_ff.sum_clear_command)
    else $error("clear command still set after completion");
  a_clear_sum: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    clear_req && !clear_done |-> ##2 running_sum == '0 && sample_tally == 8'h00)
    else $error("clear command did not zero the sum");
  a_lpf_gain: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    conv_i.done && u_core.mode == MODE_LPF && !clear_done
    |=> filtered_value_o == (running_sum >> $past(ctrl_ff.result_shift_amount)))
    else $error("filter output not scaled sum");
  a_wr_resp: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    do_write |=> s_axi_bvalid && s_axi_bresp == (wr_hit ? `AXI_OKAY : `AXI_SLVERR))
    else $error("write response wrong");
  a_rd_resp: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    rd_take |=> s_axi_rvalid && s_axi_rresp == ($past(rd_hit) ? `AXI_OKAY : `AXI_SLVERR))
    else $error("read response wrong");
  // Register side effects of writes, and control register readback
  a_rpt_write: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    wr_rpt |=> rpt_ff == $past(wdata_ff[7:0]))
    else $error("repeat target write lost");
  a_rpt_keep: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    do_write && !wr_rpt |=> rpt_ff == $past(rpt_ff))
    else $error("repeat target changed by another write");
  a_clear_sets: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    clear_req |=> ctrl_ff.sum_clear_command && clear_done)
    else $error("clear command not started");
  a_ctrl_read: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    rd_take && s_axi_araddr == ADDR_W'(`ADC_CTRL_ADDR) |=> s_axi_rdata == {24'h0, $past(ctrl_ff)})
    else $error("control readback wrong");
  c_clear_cycle: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    clear_req ##[1:3] clear_done);
  c_lpf_output: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    u_core.mode == MODE_LPF && result_valid_o);
  c_avg_output: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    u_core.mode == MODE_AVG && result_valid_o);
  c_prev_filter: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    conv_i.start && ctrl_ff.prior_source_select);
  c_burst_output: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    u_core.mode == MODE_BURST && result_valid_o);
endmodule : adc_compute_ctrl

// [bench/tb.sv]
// Self-checking bench for the converter post-processing control block.
// Assumes the constants header and package are compiled first; no checker file.
`timescale 1ns/1ps
`include "adc_compute_cfg.svh"
module tb;
  import adc_compute_pkg::*;
  localparam int SUM_W = 18;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd;
  conv_in_t conv = '0;
  logic [SUM_W-1:0] filtered_value_o;
  logic result_valid_o;
  logic [11:0] prev_value_o;
  logic [SUM_W-1:0] acc;
  int n_errors = 0;
  int n_checks = 0;

  // Clock at 25 MHz
  always #20 ref_clk_i = ~ref_clk_i;

  adc_compute_ctrl #(.ADDR_W(12), .SUM_W(SUM_W)) i_dut (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .conv_i(conv),
    .filtered_value_o(filtered_value_o), .result_valid_o(result_valid_o),
    .prev_value_o(prev_value_o)
  );

  // Value comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Bus response comparison
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_resp

  // Write one word; address and data offered together, each dropped when taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge ref_clk_i);
      aw_t = !aw_done && s_axi_awready;
      w_t = !w_done && s_axi_wready;
      @(posedge ref_clk_i);
      if (aw_t) begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_t) begin
        s_axi_wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    // Wait for the response; only the watchdog ends a hang
    do begin
      @(negedge ref_clk_i);
    end while (s_axi_bvalid !== 1'b1);
    chk_resp(s_axi_bresp, er);
    @(posedge ref_clk_i);
  endtask : axi_write

  // Read one word; rready is held high throughout
  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_t;
    ar_t = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!ar_t) begin
      @(negedge ref_clk_i);
      ar_t = s_axi_arready;
      @(posedge ref_clk_i);
    end
    s_axi_arvalid <= 1'b0;
    // Look at the answer once settled, never in its launch time step
    do begin
      @(negedge ref_clk_i);
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    chk(rd, ed);
    chk_resp(s_axi_rresp, er);
    @(posedge ref_clk_i);
  endtask : axi_read

  // Write control with clear set, then see the clear bit reading back low
  task automatic set_clear(input logic [7:0] c);
    axi_write(`ADC_CTRL_ADDR, {24'h0, c | 8'h08}, `AXI_OKAY);
    axi_read(`ADC_CTRL_ADDR, {24'h0, c & 8'hf7}, `AXI_OKAY);
    acc = '0;
  endtask : set_clear

  // One conversion done pulse and the output one cycle later
  task automatic conv_done(input logic [11:0] v, input logic ev, input logic [31:0] ex);
    conv.done <= 1'b1;
    conv.value <= v;
    @(posedge ref_clk_i);
    conv.done <= 1'b0;
    @(negedge ref_clk_i);
    chk({31'h0, result_valid_o}, {31'h0, ev});
    if (ev) chk({14'h0, filtered_value_o}, ex);
    @(posedge ref_clk_i);
  endtask : conv_done

  // One start pulse and the previous-value store a cycle later
  task automatic conv_start(input logic [11:0] ep);
    conv.start <= 1'b1;
    @(posedge ref_clk_i);
    conv.start <= 1'b0;
    @(negedge ref_clk_i);
    chk({20'h0, prev_value_o}, {20'h0, ep});
    @(posedge ref_clk_i);
  endtask : conv_start

  // Counts, verdict and end of run
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    axi_read(`ADC_CTRL_ADDR, 32'h0, `AXI_OKAY);
    axi_read(`ADC_RPT_ADDR, 32'h0, `AXI_OKAY);
    axi_write(`ADC_CTRL_ADDR, 32'hb4, `AXI_OKAY);
    axi_read(`ADC_CTRL_ADDR, 32'hb4, `AXI_OKAY);
    axi_write(12'h500, 32'h5a, `AXI_SLVERR);
    axi_read(12'h500, 32'h0, `AXI_SLVERR);
    $display("test registers done");
    // Basic mode passes samples through, shift ignored
    set_clear(8'h30);
    conv_done(12'h123, 1'b1, 32'h123);
    conv_done(12'hfff, 1'b1, 32'hfff);
    $display("test basic done");
    // Accumulate with shift one
    set_clear(8'h11);
    conv_done(12'd10, 1'b1, 32'd5);
    conv_done(12'd20, 1'b1, 32'd15);
    conv_done(12'd30, 1'b1, 32'd30);
    axi_read(`ADC_SUM_ADDR, 32'd60, `AXI_OKAY);
    axi_read(`ADC_STAT_ADDR, 32'd3, `AXI_OKAY);
    axi_write(`ADC_SUM_ADDR, 32'h0, `AXI_OKAY);
    axi_read(`ADC_SUM_ADDR, 32'd60, `AXI_OKAY);
    set_clear(8'h01);
    axi_read(`ADC_SUM_ADDR, 32'h0, `AXI_OKAY);
    axi_read(`ADC_STAT_ADDR, 32'h0, `AXI_OKAY);
    $display("test accumulate done");
    // Wrap the sum with full-scale samples, then clear the flag
    for (int i = 0; i < 65; i++) begin
      acc = acc + 18'hfff;
      conv_done(12'hfff, 1'b1, {14'h0, acc});
    end
    axi_read(`ADC_STAT_ADDR, 32'h141, `AXI_OKAY);
    set_clear(8'h01);
    axi_read(`ADC_STAT_ADDR, 32'h0, `AXI_OKAY);
    $display("test wrap and clear done");
    // Average and burst average over four samples, shift two
    axi_write(`ADC_RPT_ADDR, 32'h4, `AXI_OKAY);
    axi_read(`ADC_RPT_ADDR, 32'h4, `AXI_OKAY);
    for (int m = 2; m <= 3; m++) begin
      set_clear({5'b00100, 3'(m)});
      conv_done(12'd8, 1'b0, 32'h0);
      conv_done(12'd16, 1'b0, 32'h0);
      conv_done(12'd24, 1'b0, 32'h0);
      conv_done(12'd32, 1'b1, 32'd20);
    end
    $display("test average done");
    // Reserved mode produces nothing and leaves the tally alone
    set_clear(8'h05);
    conv_done(12'h077, 1'b0, 32'h0);
    axi_read(`ADC_STAT_ADDR, 32'h0, `AXI_OKAY);
    $display("test reserved mode done");
    // Low-pass filter, time constant two
    set_clear(8'h14);
    conv_done(12'd100, 1'b1, 32'd50);
    conv_done(12'd100, 1'b1, 32'd75);
    axi_read(`ADC_FILT_ADDR, 32'd75, `AXI_OKAY);
    $display("test filter done");
    // Previous-value source select
    axi_write(`ADC_CTRL_ADDR, 32'h94, `AXI_OKAY);
    conv_start(12'd75);
    axi_write(`ADC_CTRL_ADDR, 32'h14, `AXI_OKAY);
    conv_start(12'd100);
    $display("test previous store done");
    tally_and_finish();
  end
endmodule : tb
